// >>> rfc_defs.svh
`ifndef RFC_DEFS_SVH
`define RFC_DEFS_SVH

// Register byte addresses on the parallel bus
`define RFC_ADDR_FLAGS    17'h1_fff0
`define RFC_ADDR_CENT     17'h1_fff1
`define RFC_ADDR_ALM_SEC  17'h1_fff2

// Flags/control bit positions
`define RFC_FLG_WDOG      7
`define RFC_FLG_ALARM     6
`define RFC_FLG_DROP      5
`define RFC_FLG_CAL       2
`define RFC_FLG_W         1
`define RFC_FLG_R         0

// Alarm-seconds mask bit position
`define RFC_ALM_MASK      7

// Centuries field layout: tens in D5..D4, units in D3..D0
`define RFC_CENT_MASK     8'h3f

// Reset values
`define RFC_FLAGS_RST     8'h00
`define RFC_CENT_RST      8'h00
`define RFC_ALM_SEC_RST   8'h00
`define RFC_SEC_RST       8'h00

// BCD wrap points
`define RFC_SEC_MAX       8'h59
`define RFC_CENT_MAX      8'h99

// Oscillator edges per second and calibration tap (32768 / 64 = 512 Hz)
`define RFC_OSC_DIV       32768
`define RFC_CAL_BIT       5

// Reset value of the pin synchroniser: strobes idle high, rest low
`define RFC_SYNC_RST      30'h3800_0000

`endif

// >>> rfc_host.sv
`default_nettype none
// Host side of the asynchronous byte bus: one access at a time, strobes held
// long enough for the device's two-flop pin synchroniser to see them steady
module rfc_host (
	input  wire logic        core_clk,
	input  wire logic [7:0]  dq_wire,
	output var  logic [16:0] addr,
	output var  logic [7:0]  dq_drv,
	output var  logic        drv_en,
	output var  logic        ce_n,
	output var  logic        we_n,
	output var  logic        oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Strobe hold and gap, twice the synchroniser minimum for margin
	localparam int HOLD = 6;
	// Bus idle at time zero, strobes high
	initial begin
		addr = '0;
		dq_drv = '0;
		drv_en = 1'b0;
		ce_n = 1'b1;
		we_n = 1'b1;
		oe_n = 1'b1;
	end
	// Single byte write; data kept one cycle past the strobe so the commit sees it
	task automatic wr(input logic [16:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		dq_drv <= d;
		drv_en <= 1'b1;
		ce_n <= 1'b0;
		we_n <= 1'b0;
		repeat (HOLD) @(posedge core_clk);
		ce_n <= 1'b1;
		we_n <= 1'b1;
		@(posedge core_clk);
		drv_en <= 1'b0;
		repeat (HOLD) @(posedge core_clk);
	endtask
	// Single byte read; data taken at the edge the strobes are released
	task automatic rd(input logic [16:0] a, output logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		ce_n <= 1'b0;
		oe_n <= 1'b0;
		repeat (HOLD) @(posedge core_clk);
		d = dq_wire;
		ce_n <= 1'b1;
		oe_n <= 1'b1;
		repeat (HOLD) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// >>> rfc_pkg.sv
`default_nettype none
package rfc_pkg;
	// One register byte
	typedef logic [7:0]  rfc_byte_t;
	// Bus address
	typedef logic [16:0] rfc_addr_t;
	// Phase of the asynchronous memory bus cycle
	typedef enum logic [1:0] {
		RFC_IDLE,
		RFC_RD,
		RFC_WR
	} rfc_phase_e;
endpackage
`default_nettype wire

// >>> rfc_sync.sv
`default_nettype none
// Two-stage synchroniser for a vector of asynchronous pins
module rfc_sync #(
	parameter int              W       = 1,
	parameter logic [W-1:0]    RST_VAL = '0
) (
	input  wire logic          core_clk,
	input  wire logic          nrst,
	input  wire logic [W-1:0]  async_in,
	output var  logic [W-1:0]  sync_out
);
	logic [W-1:0] stage1;   // First stage, read only by the second

	// Both stages reset to the idle level so no false strobe appears
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			stage1   <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

// >>> rfc_top.sv
// Contract
// R1 - Alarm-seconds D7 set means ignore seconds
// R2 - Centuries: tens D5..D4, units D3..D0
// R3 - Watchdog expiry sets flag, flags read clears
// R4 - Alarm match sets flag, flags read clears
// R5 - Supply drop sets flag, flags read clears
// R6 - Calibration bit selects calibration mode output
// R7 - Write-freeze bit halts timekeeping counter updates
// R8 - Clearing write-freeze loads time into counters
// R9 - Read-capture rising edge snapshots counters
// R10 - Captured holding registers stay stable
// R11 - Software returns read-capture to zero first
// R12 - Interrupt level holds until flags read
// R13 - Flags read returns old value, clears afterwards
`include "rfc_defs.svh"
`default_nettype none
module rfc_top
	import rfc_pkg::*;
#(
	parameter int OSC_DIV = `RFC_OSC_DIV   // Oscillator edges per second tick
) (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic [16:0] bus_addr,
	input  wire logic [7:0]  bus_dq_in,
	output var  logic [7:0]  bus_dq_out,
	output logic             bus_dq_oe,
	input  wire logic        bus_ce_n,
	input  wire logic        bus_we_n,
	input  wire logic        bus_oe_n,
	input  wire logic        osc_in,
	input  wire logic        supply_low,
	input  wire logic        wdog_expire,
	input  wire logic        alarm_rest_match,
	input  wire logic        century_carry,
	output var  logic [7:0]  cur_seconds,
	output var  logic        cal_out,
	output logic             irq_n
);
	// Synchronised pins
	logic        s_ce_n;        // Chip enable, active low
	logic        s_we_n;        // Write enable, active low
	logic        s_oe_n;        // Output enable, active low
	rfc_addr_t   s_addr;        // Address
	rfc_byte_t   s_din;         // Write data
	logic        s_osc;         // Oscillator level
	logic        s_vlow;        // Supply below threshold

	rfc_sync #(
		.W       (30),
		.RST_VAL (`RFC_SYNC_RST)
	) u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.async_in ({bus_ce_n, bus_we_n, bus_oe_n, bus_addr, bus_dq_in, osc_in, supply_low}),
		.sync_out ({s_ce_n, s_we_n, s_oe_n, s_addr, s_din, s_osc, s_vlow})
	);

	// BCD increment with wrap at a given maximum
	function automatic rfc_byte_t bcd_inc(input rfc_byte_t v, input rfc_byte_t maxv);
		rfc_byte_t r;
		r = v;
		if (v == maxv) begin
			r = 8'h00;
		end else if (v[3:0] == 4'h9) begin
			r = {4'(v[7:4] + 4'h1), 4'h0};
		end else begin
			r = {v[7:4], 4'(v[3:0] + 4'h1)};
		end
		return r;
	endfunction

	// Bus phase state
	rfc_phase_e  phase, next_phase;       // Current bus cycle phase
	rfc_addr_t   wr_addr, next_wr_addr;   // Address latched during write
	rfc_byte_t   wr_data, next_wr_data;   // Data latched during write
	rfc_byte_t   next_dq_out;             // Read data for next cycle
	logic        flag_rd, next_flag_rd;   // Flags register being read
	logic        wr_cond;                 // Write strobes both active
	logic        rd_cond;                 // Read strobes active
	logic        wr_commit;               // Write strobe just ended
	logic        flag_clr;                // Flags read just completed

	assign wr_cond = !s_ce_n && !s_we_n;
	assign rd_cond = !s_ce_n && !s_oe_n && s_we_n;

	// Bus cycle tracking; a write commits when its strobe ends so the
	// data seen last before the rising strobe is the one stored
	always_comb begin
		next_phase   = phase;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		wr_commit    = 1'b0;
		unique case (phase)
			RFC_IDLE: begin
				if (wr_cond) begin
					next_phase = RFC_WR;
				end else if (rd_cond) begin
					next_phase = RFC_RD;
				end
			end
			RFC_RD: begin
				if (!rd_cond) begin
					next_phase = RFC_IDLE;
				end
			end
			RFC_WR: begin
				if (wr_cond) begin
					next_wr_addr = s_addr;
					next_wr_data = s_din;
				end else begin
					wr_commit  = 1'b1;
					next_phase = RFC_IDLE;
				end
			end
			default: begin
				next_phase = RFC_IDLE;
			end
		endcase
		if (phase == RFC_IDLE && wr_cond) begin
			next_wr_addr = s_addr;
			next_wr_data = s_din;
		end
		// Clear only once the flags read ends, so the read sees old flags
		next_flag_rd = (next_phase == RFC_RD) && (s_addr == `RFC_ADDR_FLAGS);
		flag_clr     = flag_rd && !next_flag_rd; // R13
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			phase      <= RFC_IDLE;
			wr_addr    <= '0;
			wr_data    <= '0;
			flag_rd    <= 1'b0;
			bus_dq_out <= 8'h00;
		end else begin
			phase      <= next_phase;
			wr_addr    <= next_wr_addr;
			wr_data    <= next_wr_data;
			flag_rd    <= next_flag_rd;
			bus_dq_out <= next_dq_out;
		end
	end

	// Output buffer enabled only during a read cycle
	assign bus_dq_oe = (phase == RFC_RD);

	// Control and status state
	logic        wdog_flag, next_wdog_flag;   // watchdog_expired_flag
	logic        alarm_flag, next_alarm_flag; // alarm_hit_flag
	logic        drop_flag, next_drop_flag;   // supply_drop_flag
	logic        cal, next_cal;           // Calibration select
	logic        wfrz, next_wfrz;         // Write-freeze
	logic        rcap, next_rcap;         // Read-capture
	rfc_byte_t   alm_sec, next_alm_sec;   // alarm_seconds_value
	rfc_byte_t   cent_hold, next_cent_hold; // century_count as software sees it
	rfc_byte_t   cent_cnt, next_cent_cnt; // Running century counter
	rfc_byte_t   next_sec;                // Running seconds counter
	logic [14:0] osc_cnt, next_osc_cnt;   // Oscillator edge divider
	logic [5:0]  cal_cnt, next_cal_cnt;   // Free-running calibration tap counter
	logic        osc_prev;                // Oscillator level one cycle ago
	logic        vlow_prev;               // Supply-low level one cycle ago
	logic        sec_tick;                // One-second tick
	logic        tick_d, next_tick_d;     // Seconds just advanced
	logic        alarm_hit;               // Alarm comparison true
	logic        drop_set;                // Supply just dropped
	logic        rcap_rise;               // Capture requested
	logic        wfrz_fall;               // Freeze released
	logic        live;                    // Holding follows counters
	logic        next_cal_out;            // Calibration output next value

	assign sec_tick  = s_osc && !osc_prev && (32'(osc_cnt) == OSC_DIV - 1);
	assign drop_set  = s_vlow && !vlow_prev;
	// Masked seconds leave the match to the remaining alarm fields
	assign alarm_hit = tick_d && alarm_rest_match &&
		(alm_sec[`RFC_ALM_MASK] || (cur_seconds[6:0] == alm_sec[6:0])); // R1

	// Registers, flags and timekeeping next values
	always_comb begin
		next_cal     = cal;
		next_wfrz    = wfrz;
		next_rcap    = rcap;
		next_alm_sec = alm_sec;
		if (wr_commit && wr_addr == `RFC_ADDR_FLAGS) begin
			// Status flags are read-only; only control bits take writes
			next_cal  = wr_data[`RFC_FLG_CAL];
			next_wfrz = wr_data[`RFC_FLG_W];
			next_rcap = wr_data[`RFC_FLG_R];
		end
		if (wr_commit && wr_addr == `RFC_ADDR_ALM_SEC) begin
			next_alm_sec = wr_data;
		end
		rcap_rise = !rcap && next_rcap; // R9
		wfrz_fall = wfrz && !next_wfrz; // R8
		live      = !next_wfrz && !next_rcap;

		// Set wins over a clear in the same cycle
		next_wdog_flag  = wdog_expire || (wdog_flag && !flag_clr); // R3
		next_alarm_flag = alarm_hit || (alarm_flag && !flag_clr); // R4
		next_drop_flag  = drop_set || (drop_flag && !flag_clr); // R5

		// Oscillator divider keeps running through freeze
		next_osc_cnt = osc_cnt;
		// Own tap counter: a short seconds divider must not starve the tap
		next_cal_cnt = cal_cnt;
		if (s_osc && !osc_prev) begin
			next_osc_cnt = sec_tick ? 15'h0000 : 15'(osc_cnt + 15'h0001);
			next_cal_cnt = 6'(cal_cnt + 6'h01);
		end

		next_sec      = cur_seconds;
		next_cent_cnt = cent_cnt;
		next_tick_d   = 1'b0;
		if (wfrz_fall) begin
			next_cent_cnt = cent_hold & `RFC_CENT_MASK; // R8
		end else if (!wfrz) begin
			if (sec_tick) begin
				next_sec    = bcd_inc(cur_seconds, `RFC_SEC_MAX);
				next_tick_d = 1'b1;
			end
			if (century_carry) begin
				next_cent_cnt = bcd_inc(cent_cnt, `RFC_CENT_MAX);
			end
		end // R7

		// Holding register: capture on request, then hold still
		next_cent_hold = cent_hold;
		if (wr_commit && wr_addr == `RFC_ADDR_CENT) begin
			next_cent_hold = wr_data & `RFC_CENT_MASK; // R2
		end else if (rcap_rise || live) begin
			next_cent_hold = cent_cnt & `RFC_CENT_MASK; // R9
		end // R10

		next_cal_out = cal && cal_cnt[`RFC_CAL_BIT]; // R6

		// Read data mux
		unique case (s_addr)
			`RFC_ADDR_FLAGS:   next_dq_out = {wdog_flag, alarm_flag, drop_flag, 2'b00,
				cal, wfrz, rcap};
			`RFC_ADDR_CENT:    next_dq_out = cent_hold & `RFC_CENT_MASK; // R2
			`RFC_ADDR_ALM_SEC: next_dq_out = alm_sec;
			default:           next_dq_out = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wdog_flag   <= 1'b0;
			alarm_flag  <= 1'b0;
			drop_flag   <= 1'b0;
			cal         <= 1'b0;
			wfrz        <= 1'b0;
			rcap        <= 1'b0;
			alm_sec     <= `RFC_ALM_SEC_RST;
			cent_hold   <= `RFC_CENT_RST;
			cent_cnt    <= `RFC_CENT_RST;
			cur_seconds <= `RFC_SEC_RST;
			osc_cnt     <= 15'h0000;
			cal_cnt     <= 6'h00;
			osc_prev    <= 1'b0;
			vlow_prev   <= 1'b0;
			tick_d      <= 1'b0;
			cal_out     <= 1'b0;
		end else begin
			wdog_flag   <= next_wdog_flag;
			alarm_flag  <= next_alarm_flag;
			drop_flag   <= next_drop_flag;
			cal         <= next_cal;
			wfrz        <= next_wfrz;
			rcap        <= next_rcap;
			alm_sec     <= next_alm_sec;
			cent_hold   <= next_cent_hold;
			cent_cnt    <= next_cent_cnt;
			cur_seconds <= next_sec;
			osc_cnt     <= next_osc_cnt;
			cal_cnt     <= next_cal_cnt;
			osc_prev    <= s_osc;
			vlow_prev   <= s_vlow;
			tick_d      <= next_tick_d;
			cal_out     <= next_cal_out;
		end
	end

	// Level interrupt: low while any flag stands, released by the flags read
	assign irq_n = !(wdog_flag || alarm_flag || drop_flag); // R12

	// Checks
	property p_mask;
		@(posedge core_clk) disable iff (!nrst)
		(tick_d && alarm_rest_match && alm_sec[`RFC_ALM_MASK]) |=> alarm_flag;
	endproperty
	a_mask: assert property (p_mask) else $error("masked seconds blocked alarm"); // R1

	property p_cent_top;
		@(posedge core_clk) disable iff (!nrst)
		(phase == RFC_RD && s_addr == `RFC_ADDR_CENT) |=> (bus_dq_out[7:6] == 2'b00);
	endproperty
	a_cent_top: assert property (p_cent_top) else $error("century top bits nonzero"); // R2

	property p_wdog_flag;
		@(posedge core_clk) disable iff (!nrst)
		wdog_expire |=> wdog_flag ##1 (wdog_flag || $past(flag_clr));
	endproperty
	a_wdog_flag: assert property (p_wdog_flag) else $error("watchdog flag not set"); // R3

	property p_alarm_flag;
		@(posedge core_clk) disable iff (!nrst)
		(alarm_flag && !flag_clr && !$rose(alarm_flag)) |=> alarm_flag;
	endproperty
	a_alarm_flag: assert property (p_alarm_flag) else $error("alarm flag lost unread"); // R4

	property p_drop_flag;
		@(posedge core_clk) disable iff (!nrst)
		(s_vlow && !vlow_prev) |=> (drop_flag && !irq_n);
	endproperty
	a_drop_flag: assert property (p_drop_flag) else $error("supply drop flag not set"); // R5

	property p_cal;
		@(posedge core_clk) disable iff (!nrst)
		cal_out |-> $past(cal);
	endproperty
	a_cal: assert property (p_cal) else $error("calibration output outside mode"); // R6

	property p_freeze;
		@(posedge core_clk) disable iff (!nrst)
		(wfrz && next_wfrz) |=> ($stable(cur_seconds) && $stable(cent_cnt));
	endproperty
	a_freeze: assert property (p_freeze) else $error("counters moved while frozen"); // R7

	property p_load;
		@(posedge core_clk) disable iff (!nrst)
		wfrz ##1 !wfrz |-> (cent_cnt == ($past(cent_hold, 1) & `RFC_CENT_MASK));
	endproperty
	a_load: assert property (p_load) else $error("time not loaded on freeze release"); // R8

	property p_capture;
		@(posedge core_clk) disable iff (!nrst)
		(rcap_rise && !(wr_commit && wr_addr == `RFC_ADDR_CENT))
			|=> (cent_hold == ($past(cent_cnt) & `RFC_CENT_MASK));
	endproperty
	a_capture: assert property (p_capture) else $error("snapshot not taken"); // R9

	property p_stable;
		@(posedge core_clk) disable iff (!nrst)
		(rcap && next_rcap && !(wr_commit && wr_addr == `RFC_ADDR_CENT))
			|=> $stable(cent_hold);
	endproperty
	a_stable: assert property (p_stable) else $error("holding register changed"); // R10

	property p_irq;
		@(posedge core_clk) disable iff (!nrst)
		(!irq_n && !flag_rd) |=> !irq_n;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt released without read"); // R12

	property p_rdclr;
		@(posedge core_clk) disable iff (!nrst)
		(flag_rd && next_flag_rd && wdog_flag) |=> wdog_flag;
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("flag cleared during read"); // R13
endmodule
`default_nettype wire

// >>> tb_rtc_flags_and_time_capture.sv
`include "rfc_defs.svh"
`default_nettype none
module tb_rtc_flags_and_time_capture;
	timeunit 1ns;
	timeprecision 1ps;
	import rfc_pkg::*;
	logic        core_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        osc_in = 1'b0;
	logic        supply_low = 1'b0;
	logic        wdog_expire = 1'b0;
	logic        alarm_rest_match = 1'b0;
	logic        century_carry = 1'b0;
	logic [16:0] addr;
	logic [7:0]  dq_drv, dq_out, dq_last, dq_wire, cur_seconds, v, c, s;
	logic        drv_en, dq_oe, ce_n, we_n, oe_n, cal_out, irq_n;
	int          miscompares = 0;
	int          tests_run = 0;
	int          n;
	// Released bus shows a changing pattern, never a stale byte
	assign dq_wire = dq_oe ? dq_out : (drv_en ? dq_drv : ~dq_last);
	always @(posedge core_clk) dq_last <= dq_wire;
	initial dq_last = 8'h00;
	initial forever #10 core_clk = ~core_clk;
	// Fast oscillator stand-in, its edges fixed on core clock falling edges (period 40 core cycles)
	initial forever #400 osc_in = ~osc_in;
	rfc_host host (.core_clk(core_clk), .dq_wire(dq_wire), .addr(addr), .dq_drv(dq_drv),
		.drv_en(drv_en), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n));
	// Shortened seconds divider: 8 oscillator edges per tick
	rfc_top #(.OSC_DIV(8)) dut (.core_clk(core_clk), .nrst(nrst), .bus_addr(addr),
		.bus_dq_in(dq_wire), .bus_dq_out(dq_out), .bus_dq_oe(dq_oe), .bus_ce_n(ce_n),
		.bus_we_n(we_n), .bus_oe_n(oe_n), .osc_in(osc_in), .supply_low(supply_low),
		.wdog_expire(wdog_expire), .alarm_rest_match(alarm_rest_match),
		.century_carry(century_carry), .cur_seconds(cur_seconds), .cal_out(cal_out),
		.irq_n(irq_n));
	// BCD increment of the century count
	function automatic logic [7:0] bcd_inc(input logic [7:0] b);
		return (b[3:0] == 4'h9) ? {b[7:4] + 4'h1, 4'h0} : b + 8'h01;
	endfunction
	// Compare and count
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic pulse_carry();
		@(posedge core_clk) century_carry <= 1'b1;
		@(posedge core_clk) century_carry <= 1'b0;
	endtask
	task automatic results();
		if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Main sequence
	initial begin
		void'($urandom(32'hc5a007f6));
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		host.rd(`RFC_ADDR_FLAGS, v);
		chk("flags reset", v, `RFC_FLAGS_RST);
		host.rd(`RFC_ADDR_CENT, v);
		chk("century reset", v, `RFC_CENT_RST);
		host.rd(`RFC_ADDR_ALM_SEC, v);
		chk("alarm reset", v, `RFC_ALM_SEC_RST);
		// Random alarm-seconds bytes read back whole
		repeat (3) begin
			c = 8'($urandom);
			host.wr(`RFC_ADDR_ALM_SEC, c);
			host.rd(`RFC_ADDR_ALM_SEC, v);
			chk("alarm rw", v, c);
		end
		// Unmapped place and status bits refuse writes
		host.wr(17'h1_fff8, 8'hff);
		host.rd(17'h1_fff8, v);
		chk("unmapped", v, 8'h00);
		host.wr(`RFC_ADDR_FLAGS, 8'he0);
		host.rd(`RFC_ADDR_FLAGS, v);
		chk("status ro", v, 8'h00);
		// Watchdog flag: held interrupt, old value on read, then cleared
		@(posedge core_clk) wdog_expire <= 1'b1;
		@(posedge core_clk) wdog_expire <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("irq low", {7'b0, irq_n}, 8'h00);
		host.rd(`RFC_ADDR_FLAGS, v);
		chk("wdog flag", v, 8'h80);
		chk("irq high", {7'b0, irq_n}, 8'h01);
		host.rd(`RFC_ADDR_FLAGS, v);
		chk("wdog clr", v, 8'h00);
		@(posedge core_clk) supply_low <= 1'b1;
		repeat (6) @(posedge core_clk);
		host.rd(`RFC_ADDR_FLAGS, v);
		chk("supply flag", v, 8'h20);
		host.rd(`RFC_ADDR_FLAGS, v);
		chk("supply clr", v, 8'h00);
		supply_low <= 1'b0;
		// Load a random century through freeze and release
		c = {2'($urandom), 2'($urandom), 4'($urandom_range(0, 9))};
		host.wr(`RFC_ADDR_FLAGS, 8'h02);
		host.wr(`RFC_ADDR_CENT, c);
		host.wr(`RFC_ADDR_FLAGS, 8'h00);
		c = c & `RFC_CENT_MASK;
		host.rd(`RFC_ADDR_CENT, v);
		chk("century load", v, c);
		pulse_carry();
		c = bcd_inc(c);
		host.rd(`RFC_ADDR_CENT, v);
		chk("century inc", v, c);
		// Snapshot stays put while the counter moves on
		host.wr(`RFC_ADDR_FLAGS, 8'h01);
		pulse_carry();
		host.rd(`RFC_ADDR_CENT, v);
		chk("snapshot", v, c);
		host.wr(`RFC_ADDR_FLAGS, 8'h00);
		host.wr(`RFC_ADDR_FLAGS, 8'h01);
		host.rd(`RFC_ADDR_CENT, v);
		chk("recapture", v, bcd_inc(c));
		host.wr(`RFC_ADDR_FLAGS, 8'h00);
		// Frozen seconds hold across two ticks, then run again
		host.wr(`RFC_ADDR_FLAGS, 8'h02);
		s = cur_seconds;
		repeat (700) @(posedge core_clk);
		chk("frozen", cur_seconds, s);
		host.wr(`RFC_ADDR_FLAGS, 8'h00);
		repeat (700) @(posedge core_clk);
		chk("running", {7'b0, cur_seconds !== s}, 8'h01);
		// Alarm: masked seconds match on any tick, unmasked far value never does
		host.wr(`RFC_ADDR_ALM_SEC, 8'h80);
		alarm_rest_match <= 1'b1;
		repeat (700) @(posedge core_clk);
		host.rd(`RFC_ADDR_FLAGS, v);
		chk("alarm masked", v, 8'h40);
		host.wr(`RFC_ADDR_ALM_SEC, `RFC_SEC_MAX);
		host.rd(`RFC_ADDR_FLAGS, v);
		repeat (700) @(posedge core_clk);
		host.rd(`RFC_ADDR_FLAGS, v);
		chk("alarm unmatched", v, 8'h00);
		// Unmasked seconds two ticks ahead: the match itself must set the flag
		s = bcd_inc(bcd_inc(cur_seconds));
		host.wr(`RFC_ADDR_ALM_SEC, s);
		repeat (700) @(posedge core_clk);
		host.rd(`RFC_ADDR_FLAGS, v);
		chk("alarm matched", v, 8'h40);
		alarm_rest_match <= 1'b0;
		// Calibration square wave only while selected
		chk("cal idle", {7'b0, cal_out}, 8'h00);
		host.wr(`RFC_ADDR_FLAGS, 8'h04);
		for (n = 0; n < 3000 && cal_out !== 1'b1; n++) @(posedge core_clk);
		chk("cal on", {7'b0, cal_out}, 8'h01);
		if (n == 3000) results();
		host.wr(`RFC_ADDR_FLAGS, 8'h00);
		repeat (4) @(posedge core_clk);
		chk("cal off", {7'b0, cal_out}, 8'h00);
		results();
	end
endmodule
`default_nettype wire
